// ---- accel_fifo_status_config_regs.v ----
// Register bank of the accelerometer: byte queue, fill count, internal
// status and rate, filter and range configuration.
// Assumes a host interface front end on mclk issuing one-cycle read and
// write strobes, and sample logic on mclk pushing bytes into the queue.
// Behaviour
// - Low fill-count register shows queue byte count bits 7:0, reset zero.
// - High fill-count register shows count bits 13:8 in 5:0, 7:6 zero.
// - Queue read port returns queue data, reads zero after reset.
// - Status bits 4:0 carry the initialization message code.
// - Status bit 5 flags axes not mapped to distinct physical axes.
// - Status bit 6 flags rate below 50 Hz needed by features.
// - Rate field bits 3:0 codes 1..12 select 25/32 Hz to 1600 Hz.
// - Rate selection is independent of the power mode setting.
// - Style 1: bandwidth 0 fourfold, 1 twofold oversampling, 2 normal.
// - Style 0: bandwidth code n averages 2 to the n samples.
// - Bit 7 selects averaging at 0, continuous filter at 1.
// - Rate and filter register is read-write, resets to 0xa8.
// - Range field bits 1:0 select 2g to 16g, resets to 1.
`timescale 1ns/1ps
`default_nettype none
`include "accel_regs_consts.vh"
module accel_fifo_status_config_regs (
   input  wire       mclk,
   input  wire       reset,
   input  wire [7:0] reg_addr,
   input  wire       reg_rd,
   input  wire       reg_wr,
   input  wire [7:0] reg_wdata,
   output reg  [7:0] reg_rdata,
   output reg        reg_rvalid,
   input  wire       sample_valid,
   output reg        sample_ready,
   input  wire [7:0] sample_data,
   input  wire [4:0] init_message,
   input  wire [1:0] map_x,
   input  wire [1:0] map_y,
   input  wire [1:0] map_z,
   input  wire       low_rate_feature_on,
   input  wire       low_power_mode,
   output reg  [3:0] rate_code,
   output reg        rate_valid,
   output reg        filter_continuous,
   output reg        fourfold_oversample,
   output reg        twofold_oversample,
   output reg        filter_normal,
   output reg  [2:0] avg_log2,
   output reg  [1:0] full_scale
);
   localparam ST_IDLE = 2'b01;
   localparam ST_MOVE = 2'b10;

   reg  [7:0]              mem_r [0:`QUEUE_DEPTH-1];
   reg  [`QUEUE_AW-1:0]    wptr_r;
   reg  [`QUEUE_AW-1:0]    rptr_r;
   reg  [`FILL_W-1:0]      fill_r;
   reg  [7:0]              port_r;
   reg  [7:0]              conf_r;
   reg  [1:0]              scale_r;
   reg  [1:0]              st_r;
   reg  [1:0]              st_nxt;
   reg  [7:0]              rdata_nxt;
   wire                    buf_valid;
   wire                    buf_ready;
   wire [7:0]              buf_data;
   wire                    buf_in_ready;
   wire                    buf_take;
   wire                    buf_full_nxt;
   wire                    q_full;
   wire                    q_empty;
   wire                    q_push;
   wire                    q_pop;
   wire                    remap_err;
   wire                    rate_err;
   wire [2:0]              bw;
   wire [3:0]              rate;

   pair_buffer #(
      .WIDTH (8),
      .DEPTH (`BUF_DEPTH)
   ) u_buf (
      .mclk      (mclk),
      .reset     (reset),
      .in_valid  (buf_take),
      .in_ready  (buf_in_ready),
      .in_data   (sample_data),
      .out_valid (buf_valid),
      .out_ready (buf_ready),
      .out_data  (buf_data)
   );

   // Ready is registered, so it promises room one cycle ahead
   assign buf_take     = sample_valid & sample_ready;
   assign buf_full_nxt = buf_in_ready ? (buf_valid & buf_take & ~q_push) : ~q_push;
   assign q_full    = (fill_r == `QUEUE_DEPTH);
   assign q_empty   = (fill_r == `RST_FILL);
   assign buf_ready = ~q_full & (st_r == ST_MOVE);
   assign q_push    = buf_valid & buf_ready;
   assign q_pop     = reg_rd & (reg_addr == `ADDR_QUEUE_PORT) & ~q_empty;
   assign bw        = conf_r[`BW_MSB:`BW_LSB];
   assign rate      = conf_r[`RATE_MSB:`RATE_LSB];

   assign remap_err = (map_x == map_y) | (map_x == map_z) | (map_y == map_z);
   assign rate_err  = low_rate_feature_on & (rate < `RATE_50HZ);

   // Mover alternates idle and move to pace queue writes
   always @* begin
      case (st_r)
         ST_IDLE: st_nxt = buf_valid ? ST_MOVE : ST_IDLE;
         ST_MOVE: st_nxt = buf_valid & ~q_push ? ST_MOVE : ST_IDLE;
         default: st_nxt = ST_IDLE;
      endcase
   end

   always @(posedge mclk) begin
      if (q_push)
         mem_r[wptr_r] <= buf_data;
   end

   always @(posedge mclk or posedge reset) begin
      if (reset) begin
         st_r   <= ST_IDLE;
         wptr_r <= {`QUEUE_AW{1'b0}};
         rptr_r <= {`QUEUE_AW{1'b0}};
         fill_r <= `RST_FILL;
         port_r <= `RST_QUEUE_PORT;
      end else begin
         st_r <= st_nxt;
         if (q_push)
            wptr_r <= wptr_r + 1'b1;
         if (q_pop) begin
            rptr_r <= rptr_r + 1'b1;
            port_r <= mem_r[rptr_r];
         end
         if (q_push & ~q_pop)
            fill_r <= fill_r + 1'b1;
         else if (q_pop & ~q_push)
            fill_r <= fill_r - 1'b1;
      end
   end

   always @(posedge mclk or posedge reset) begin
      if (reset) begin
         conf_r  <= `RST_RATE_CONF;
         scale_r <= `RST_FULL_SCALE;
      end else if (reg_wr) begin
         if (reg_addr == `ADDR_RATE_CONF)
            conf_r <= reg_wdata;
         if (reg_addr == `ADDR_FULL_SCALE)
            scale_r <= reg_wdata[1:0];
      end
   end

   always @* begin
      rdata_nxt = 8'h00;
      case (reg_addr)
         `ADDR_FILL_LOW:   rdata_nxt = fill_r[7:0];
         `ADDR_FILL_HIGH:  rdata_nxt = {2'b00, fill_r[`FILL_W-1:8]};
         `ADDR_QUEUE_PORT: rdata_nxt = q_empty ? port_r : mem_r[rptr_r];
         `ADDR_STATUS:     rdata_nxt = {1'b0, rate_err, remap_err, init_message};
         `ADDR_RATE_CONF:  rdata_nxt = conf_r;
         `ADDR_FULL_SCALE: rdata_nxt = {6'h00, scale_r};
         default:          rdata_nxt = 8'h00;
      endcase
   end

   always @(posedge mclk or posedge reset) begin
      if (reset) begin
         reg_rdata           <= 8'h00;
         reg_rvalid          <= 1'b0;
         sample_ready        <= 1'b0;
         rate_code           <= `RST_RATE_CODE;
         rate_valid          <= 1'b1;
         filter_continuous   <= 1'b1;
         fourfold_oversample <= 1'b0;
         twofold_oversample  <= 1'b0;
         filter_normal       <= 1'b1;
         avg_log2            <= `RST_AVG_LOG2;
         full_scale          <= `RST_FULL_SCALE;
      end else begin
         reg_rvalid   <= reg_rd;
         if (reg_rd)
            reg_rdata <= rdata_nxt;
         sample_ready <= ~buf_full_nxt;
         rate_code  <= rate;
         rate_valid <= (rate >= `RATE_MIN) & (rate <= `RATE_MAX);
         filter_continuous   <= conf_r[`STYLE_BIT];
         fourfold_oversample <= conf_r[`STYLE_BIT] & (bw == `BW_FOUR_OS);
         twofold_oversample  <= conf_r[`STYLE_BIT] & (bw == `BW_TWO_OS);
         filter_normal       <= conf_r[`STYLE_BIT] & (bw == `BW_NORMAL);
         avg_log2   <= conf_r[`STYLE_BIT] ? 3'h0 : bw;
         full_scale <= scale_r;
      end
   end
endmodule
`default_nettype wire

// ---- accel_fifo_status_config_regs_tb_top.sv ----
// Self-checking bench of the accelerometer register bank.
// Assumes the bank, its bound checker and the byte source model.
`timescale 1ns/1ps
`default_nettype none
`define chk(a, e) begin checks_done++; if ((a) !== (e)) begin fail_count++; \
   $display("mismatch %0t %h %h", $time, a, e); end end
module accel_fifo_status_config_regs_tb_top;
   logic       mclk = 1'b0;
   logic       reset, reg_rd, reg_wr, reg_rvalid, sample_valid, sample_ready, feat, lpm;
   logic [7:0] reg_addr, reg_wdata, reg_rdata, sample_data;
   logic [4:0] init_message;
   logic [1:0] map_x, map_y, map_z;
   int         fail_count = 0;
   int         checks_done = 0;
   always #10 mclk = ~mclk;
   accel_fifo_status_config_regs dut (.mclk, .reset, .reg_addr, .reg_rd, .reg_wr, .reg_wdata,
      .reg_rdata, .reg_rvalid, .sample_valid, .sample_ready, .sample_data, .init_message,
      .map_x, .map_y, .map_z, .low_rate_feature_on(feat), .low_power_mode(lpm),
      .rate_code(), .rate_valid(), .filter_continuous(), .fourfold_oversample(),
      .twofold_oversample(), .filter_normal(), .avg_log2(), .full_scale());
   byte_source src (.mclk, .sample_ready, .sample_valid, .sample_data);
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge mclk);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge mclk);
      reg_wr    <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      @(posedge mclk);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge mclk);
      reg_rd   <= 1'b0;
      @(negedge mclk);
      `chk({reg_rvalid, reg_rdata}, {1'b1, e})
      @(posedge mclk);
   endtask
   task automatic complete_run;
      if (fail_count == 0 && checks_done > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge mclk);
      fail_count++;
      complete_run;
   end
   initial begin
      {reset, reg_rd, reg_wr, feat, reg_addr, reg_wdata, init_message} = {4'h8, 21'h0};
      {map_x, map_y, map_z} = {2'h0, 2'h1, 2'h2};
      lpm = 1'b0;
      repeat (6) @(posedge mclk);
      reset <= 1'b0;
      repeat (2) @(posedge mclk);
      rd(8'h24, 8'h00);
      rd(8'h25, 8'h00);
      rd(8'h26, 8'h00);
      rd(8'h40, 8'ha8);
      rd(8'h41, 8'h01);
      wr(8'h24, 8'hff);
      rd(8'h24, 8'h00);
      rd(8'h30, 8'h00);
      for (int i = 0; i < 5; i++) begin
         init_message <= i[4:0];
         rd(8'h2a, {3'h0, i[4:0]});
      end
      init_message <= 5'h00;
      map_z <= 2'h0;
      rd(8'h2a, 8'h20);
      map_z <= 2'h2;
      feat <= 1'b1;
      wr(8'h40, 8'ha6);
      rd(8'h2a, 8'h40);
      wr(8'h40, 8'ha7);
      rd(8'h2a, 8'h00);
      feat <= 1'b0;
      for (int i = 0; i < 16; i++) begin
         lpm <= i[0];
         wr(8'h40, {i[3:0], i[3:0]});
         rd(8'h40, {i[3:0], i[3:0]});
      end
      lpm <= 1'b0;
      for (int i = 0; i < 4; i++) begin
         wr(8'h41, {6'h3f, i[1:0]});
         rd(8'h41, {6'h00, i[1:0]});
      end
      src.push(8'h50, 5);
      repeat (8) @(posedge mclk);
      rd(8'h24, 8'h05);
      rd(8'h25, 8'h00);
      for (int i = 0; i < 5; i++) begin
         rd(8'h26, 8'h50 + i[7:0]);
         rd(8'h24, 8'h04 - i[7:0]);
      end
      rd(8'h26, 8'h54);
      src.push(8'h60, 2);
      repeat (6) @(posedge mclk);
      rd(8'h24, 8'h02);
      reset <= 1'b1;
      repeat (2) @(posedge mclk);
      reset <= 1'b0;
      repeat (2) @(posedge mclk);
      rd(8'h24, 8'h00);
      rd(8'h26, 8'h00);
      rd(8'h40, 8'ha8);
      rd(8'h41, 8'h01);
      complete_run;
   end
endmodule
`default_nettype wire

// ---- accel_regs_chk.sv ----
// Port checker of the accelerometer register bank.
// Assumes binding to the bank top, one clock domain on mclk.
`timescale 1ns/1ps
`default_nettype none
module accel_regs_chk (
   input wire logic       mclk,
   input wire logic       reset,
   input wire logic [7:0] reg_addr,
   input wire logic       reg_rd,
   input wire logic       reg_wr,
   input wire logic [7:0] reg_wdata,
   input wire logic [7:0] reg_rdata,
   input wire logic       reg_rvalid,
   input wire logic [4:0] init_message,
   input wire logic [1:0] map_x,
   input wire logic [1:0] map_y,
   input wire logic [1:0] map_z,
   input wire logic [3:0] rate_code,
   input wire logic       rate_valid,
   input wire logic       filter_continuous,
   input wire logic       fourfold_oversample,
   input wire logic       twofold_oversample,
   input wire logic       filter_normal,
   input wire logic [2:0] avg_log2,
   input wire logic [1:0] full_scale
);
   wire axis_clash = (map_x == map_y) || (map_x == map_z) || (map_y == map_z);
   wire conf_wr = reg_wr && (reg_addr == 8'h40);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (reset);
   a_read_answer: assert property (reg_rd |=> reg_rvalid)
      else $error("read not answered");
   a_no_stray_answer: assert property (reg_rvalid |-> $past(reg_rd))
      else $error("answer without read");
   a_status_message: assert property (reg_rd && reg_addr == 8'h2a
      |=> reg_rdata[4:0] == $past(init_message)) else $error("status code wrong");
   a_remap_flag: assert property (reg_rd && reg_addr == 8'h2a
      |=> reg_rdata[5] == $past(axis_clash)) else $error("remap flag wrong");
   a_high_reserved: assert property (reg_rd && reg_addr == 8'h25
      |=> reg_rdata[7:6] == 2'h0) else $error("reserved count bits set");
   a_rate_valid: assert property (rate_valid == (rate_code >= 4'h1 && rate_code <= 4'hc))
      else $error("rate valid wrong");
   a_style_follow: assert property (conf_wr
      |-> ##2 filter_continuous == $past(reg_wdata[7], 2)) else $error("style wrong");
   a_avg_follow: assert property (conf_wr |-> ##2 avg_log2 ==
      ($past(reg_wdata[7], 2) ? 3'h0 : $past(reg_wdata[6:4], 2))) else $error("avg wrong");
   a_fourfold_follow: assert property (conf_wr |-> ##2 fourfold_oversample ==
      ($past(reg_wdata[7], 2) && $past(reg_wdata[6:4], 2) == 3'h0)) else $error("osr wrong");
   a_range_follow: assert property (reg_wr && reg_addr == 8'h41
      |-> ##2 full_scale == $past(reg_wdata[1:0], 2)) else $error("range wrong");
   a_rate_follow: assert property (conf_wr
      |-> ##2 rate_code == $past(reg_wdata[3:0], 2)) else $error("rate code wrong");
   a_twofold_follow: assert property (conf_wr |-> ##2 twofold_oversample ==
      ($past(reg_wdata[7], 2) && $past(reg_wdata[6:4], 2) == 3'h1)) else $error("twofold_oversample wrong");
   a_normal_follow: assert property (conf_wr |-> ##2 filter_normal ==
      ($past(reg_wdata[7], 2) && $past(reg_wdata[6:4], 2) == 3'h2)) else $error("normal wrong");
endmodule
bind accel_fifo_status_config_regs accel_regs_chk chk_i (.mclk, .reset, .reg_addr, .reg_rd,
   .reg_wr, .reg_wdata, .reg_rdata, .reg_rvalid, .init_message, .map_x, .map_y, .map_z,
   .rate_code, .rate_valid, .filter_continuous, .fourfold_oversample, .twofold_oversample,
   .filter_normal, .avg_log2, .full_scale);
`default_nettype wire

// ---- accel_regs_consts.vh ----
// Register offsets, field positions, reset values and codes of the
// accelerometer register bank.
// Assumes inclusion by bare name from the design files.
`ifndef ACCEL_REGS_CONSTS_VH
`define ACCEL_REGS_CONSTS_VH

`define ADDR_FILL_LOW      8'h24
`define ADDR_FILL_HIGH     8'h25
`define ADDR_QUEUE_PORT    8'h26
`define ADDR_STATUS        8'h2a
`define ADDR_RATE_CONF     8'h40
`define ADDR_FULL_SCALE    8'h41

`define RST_FILL           14'h0000
`define RST_QUEUE_PORT     8'h00
`define RST_STATUS         8'h00
`define RST_RATE_CONF      8'ha8
`define RST_FULL_SCALE     2'h1
`define RST_RATE_CODE      4'h8
`define RST_AVG_LOG2       3'h0

`define MSG_NOT_INIT       5'h00
`define MSG_INIT_OK        5'h01
`define MSG_INIT_ERR       5'h02
`define MSG_DRV_ERR        5'h03
`define MSG_SNS_STOP       5'h04

`define RATE_LSB           0
`define RATE_MSB           3
`define BW_LSB             4
`define BW_MSB             6
`define STYLE_BIT          7
`define RATE_MIN           4'h1
`define RATE_MAX           4'hc
`define RATE_50HZ          4'h7
`define BW_FOUR_OS         3'h0
`define BW_TWO_OS          3'h1
`define BW_NORMAL          3'h2

`define AXIS_X             2'h0
`define AXIS_Y             2'h1
`define AXIS_Z             2'h2

`define FILL_W             14
`define FILL_HIGH_W        6
`define QUEUE_DEPTH        1024
`define QUEUE_AW           10

`define BUF_DEPTH          2

`endif

// ---- byte_source.sv ----
// Sample byte source feeding the queue input.
// Assumes the bank takes a byte offered while its input is ready.
`timescale 1ns/1ps
`default_nettype none
module byte_source (
   input  wire logic       mclk,
   input  wire logic       sample_ready,
   output var  logic       sample_valid,
   output var  logic [7:0] sample_data
);
   initial begin
      sample_valid = 1'b0;
      sample_data  = 8'h00;
   end
   // Each byte holds until an edge sees ready high
   // Idle data shows the inverse of the last byte
   task automatic push(input logic [7:0] first, input int n);
      @(posedge mclk);
      for (int i = 0; i < n; i++) begin
         sample_valid <= 1'b1;
         sample_data  <= first + i[7:0];
         @(posedge mclk);
         while (!sample_ready) @(posedge mclk);
      end
      sample_valid <= 1'b0;
      sample_data  <= ~(first + n[7:0] - 8'h01);
   endtask
endmodule
`default_nettype wire

// ---- pair_buffer.v ----
// Two-entry valid/ready buffer for 8-bit words.
// Assumes source and sink on the same clock as the buffer.
`timescale 1ns/1ps
`default_nettype none
module pair_buffer #(
   parameter WIDTH = 8,
   parameter DEPTH = 2
) (
   input  wire             mclk,
   input  wire             reset,
   input  wire             in_valid,
   output wire             in_ready,
   input  wire [WIDTH-1:0] in_data,
   output wire             out_valid,
   input  wire             out_ready,
   output wire [WIDTH-1:0] out_data
);
   reg [WIDTH-1:0] slot_r [0:DEPTH-1];
   reg             wp_r;
   reg             rp_r;
   reg [1:0]       cnt_r;
   wire            push;
   wire            pop;

   assign in_ready  = (cnt_r != 2'd2);
   assign out_valid = (cnt_r != 2'd0);
   assign out_data  = slot_r[rp_r];
   assign push      = in_valid & in_ready;
   assign pop       = out_valid & out_ready;

   always @(posedge mclk or posedge reset) begin
      if (reset) begin
         wp_r     <= 1'b0;
         rp_r     <= 1'b0;
         cnt_r    <= 2'd0;
         slot_r[0] <= {WIDTH{1'b0}};
         slot_r[1] <= {WIDTH{1'b0}};
      end else begin
         if (push) begin
            slot_r[wp_r] <= in_data;
            wp_r         <= ~wp_r;
         end
         if (pop)
            rp_r <= ~rp_r;
         if (push & ~pop)
            cnt_r <= cnt_r + 2'd1;
         else if (pop & ~push)
            cnt_r <= cnt_r - 2'd1;
      end
   end
endmodule
`default_nettype wire
